// *** rtl/compare_read_eval.sv ***
/*
	compare-read evaluation of one 128-bit flash word
	assumes the top registers the result and gives word index 0 for the lowest word
*/
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"

module compare_read_eval (
	flash_path_if.cmp_unit  path
);
	logic  all_ones;

	assign all_ones = &path.flash_word;

	// plain reads pass the addressed word; compare reads look at the whole flash word
	always_comb
	begin
		if (!path.compare_active)
			path.read_word = path.flash_word[path.word_sel * 32 +: 32];
		else if (!all_ones)
			path.read_word = `CMP_FAIL_WORD;
		else if (path.word_sel == 2'b00)
			path.read_word = `CMP_LOW_WORD;
		else
			path.read_word = `CMP_OTHER_WORD;
	end
endmodule // compare_read_eval

// *** rtl/flash_verify_retry_panel_swap_lock_ctrl.sv ***
/*
	flash program control two register with compare read, erase retry selection,
	verify wait-state source and panel swap locking
	assumes a register master that never asserts both strobes and needs no wait,
	and a flash array that presents its word on the same clock
*/
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"

// How it works
// - compare read only acts when both compare bit and verify bit are set
// - compare read of all-ones word gives 1 for lowest word, 0x10000 otherwise
// - compare read with any zero bit gives zero for every word
// - verify bit chooses retry erase with verify, else single erase
// - with verify set, wait states come from addressed panel's low-power field
// - retry field codes strength: 00 first, 01 second, 10 third, 11 last
// - retry strength is applied only while verify bit is set
// - lock 00 lets swap bits and lock field be written
// - lock 01 or 10 blocks swap bits but lock field stays writable
// - lock 11 blocks swap bits and the lock field itself
// - compare, verify, retry bits change only with write enable low and key done
// - unused bits 11:10 and 5:0 of control two read zero
module flash_verify_retry_panel_swap_lock_ctrl (
	input  wire logic          sys_clk_in,
	input  wire logic          rst_in,
	input  wire logic [7:0]    reg_addr_in,
	input  wire logic [31:0]   reg_wdata_in,
	input  wire logic          reg_wr_in,
	input  wire logic          reg_rd_in,
	output logic [31:0]        reg_rdata_out,
	input  wire logic          flash_rd_in,
	input  wire logic [127:0]  flash_word_in,
	input  wire logic [1:0]    flash_word_sel_in,
	output logic [31:0]        flash_rd_data_out,
	input  wire logic [4:0]    normal_waitstates_in,
	output logic [4:0]         wait_states_out,
	output logic               erase_retry_mode_out,
	output logic [1:0]         erase_retry_strength_out,
	output logic               program_panel_swap_out,
	output logic               boot_panel_swap_out,
	output logic [31:0]        flash_target_address_out
);
	logic                          compare_read_one_en;
	logic                          verify_read_one_sel;
	logic [1:0]                    erase_retry_strength;
	logic [1:0]                    panel_swap_lock;
	logic                          program_panel_swap;
	logic                          boot_panel_swap;
	logic                          flash_write_enable;
	flash_ctrl_pkg::waitstate_t    lp_ws_panel0;
	flash_ctrl_pkg::waitstate_t    lp_ws_panel1;
	logic [31:0]                   flash_target_address;
	flash_ctrl_pkg::key_state_t    key_state;
	flash_ctrl_pkg::key_state_t    next_key_state;
	flash_ctrl_pkg::erase_mode_t   erase_mode;
	logic                          ctrl_wr;
	logic                          swap_wr;
	logic                          protected_ok;
	logic [31:0]                   next_rdata;

	flash_path_if  path ();

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction

	assign ctrl_wr = reg_wr_in && hit(reg_addr_in, `FPC2_OFFSET);
	assign swap_wr = reg_wr_in && hit(reg_addr_in, `SWAP_OFFSET);

	// the key opens exactly one write; any other write in between spends it
	// a fresh first key word always restarts the sequence, so a retry never locks out
	always_comb
	begin
		next_key_state = key_state;
		unique case (key_state)
			flash_ctrl_pkg::KEY_IDLE:
				if (reg_wr_in && hit(reg_addr_in, `KEY_OFFSET) && reg_wdata_in == `KEY_FIRST)
					next_key_state = flash_ctrl_pkg::KEY_HALF;
			flash_ctrl_pkg::KEY_HALF:
				if (reg_wr_in)
				begin
					if (hit(reg_addr_in, `KEY_OFFSET) && reg_wdata_in == `KEY_SECOND)
						next_key_state = flash_ctrl_pkg::KEY_OPEN;
					else if (hit(reg_addr_in, `KEY_OFFSET) && reg_wdata_in == `KEY_FIRST)
						next_key_state = flash_ctrl_pkg::KEY_HALF;
					else
						next_key_state = flash_ctrl_pkg::KEY_IDLE;
				end
			flash_ctrl_pkg::KEY_OPEN:
				if (reg_wr_in)
				begin
					if (hit(reg_addr_in, `KEY_OFFSET) && reg_wdata_in == `KEY_FIRST)
						next_key_state = flash_ctrl_pkg::KEY_HALF;
					else
						next_key_state = flash_ctrl_pkg::KEY_IDLE;
				end
			default:
				next_key_state = flash_ctrl_pkg::KEY_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			key_state <= flash_ctrl_pkg::KEY_IDLE;
		else
			key_state <= next_key_state;
	end

	assign protected_ok = (key_state == flash_ctrl_pkg::KEY_OPEN) && !flash_write_enable;

	// refused writes are dropped silently; the port has no error answer
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			compare_read_one_en  <= 1'b0;
			verify_read_one_sel  <= 1'b0;
			erase_retry_strength <= `RETRY_FIRST;
		end
		else if (ctrl_wr && protected_ok)
		begin
			compare_read_one_en  <= reg_wdata_in[`CMP_RD_BIT];
			verify_read_one_sel  <= reg_wdata_in[`VRFY_BIT];
			erase_retry_strength <= reg_wdata_in[`RETRY_HI:`RETRY_LO];
		end
	end

	// lock field guards itself only at the final code
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			panel_swap_lock <= `LOCK_OPEN;
		else if (ctrl_wr && panel_swap_lock != `LOCK_FINAL)
			panel_swap_lock <= reg_wdata_in[`LOCK_HI:`LOCK_LO];
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			program_panel_swap <= 1'b0;
			boot_panel_swap    <= 1'b0;
		end
		else if (swap_wr && panel_swap_lock == `LOCK_OPEN)
		begin
			program_panel_swap <= reg_wdata_in[`PSWAP_BIT];
			boot_panel_swap    <= reg_wdata_in[`BSWAP_BIT];
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			flash_write_enable <= 1'b0;
		else if (reg_wr_in && hit(reg_addr_in, `CTRL1_OFFSET))
			flash_write_enable <= reg_wdata_in[`WEN_BIT];
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			lp_ws_panel0 <= `WS_RESET;
			lp_ws_panel1 <= `WS_RESET;
		end
		else if (reg_wr_in && hit(reg_addr_in, `LPWS_OFFSET))
		begin
			lp_ws_panel0 <= reg_wdata_in[`LPWS0_LO +: `WS_W];
			lp_ws_panel1 <= reg_wdata_in[`LPWS1_LO +: `WS_W];
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			flash_target_address <= `REG_RESET;
		else if (reg_wr_in && hit(reg_addr_in, `ADDR_OFFSET))
			flash_target_address <= reg_wdata_in;
	end

	assign erase_mode = verify_read_one_sel ? flash_ctrl_pkg::ERASE_RETRY
	                                        : flash_ctrl_pkg::ERASE_SINGLE;

	// unused positions are simply never placed into the word
	always_comb
	begin
		next_rdata = `REG_RESET;
		if (reg_rd_in)
		begin
			if (hit(reg_addr_in, `FPC2_OFFSET))
			begin
				next_rdata[`CMP_RD_BIT]          = compare_read_one_en;
				next_rdata[`VRFY_BIT]            = verify_read_one_sel;
				next_rdata[`RETRY_HI:`RETRY_LO]  = erase_retry_strength;
				next_rdata[`LOCK_HI:`LOCK_LO]    = panel_swap_lock;
			end
			else if (hit(reg_addr_in, `SWAP_OFFSET))
			begin
				next_rdata[`PSWAP_BIT] = program_panel_swap;
				next_rdata[`BSWAP_BIT] = boot_panel_swap;
			end
			else if (hit(reg_addr_in, `CTRL1_OFFSET))
				next_rdata[`WEN_BIT] = flash_write_enable;
			else if (hit(reg_addr_in, `LPWS_OFFSET))
			begin
				next_rdata[`LPWS0_LO +: `WS_W] = lp_ws_panel0;
				next_rdata[`LPWS1_LO +: `WS_W] = lp_ws_panel1;
			end
			else if (hit(reg_addr_in, `ADDR_OFFSET))
				next_rdata = flash_target_address;
			else if (hit(reg_addr_in, `STATUS_OFFSET))
			begin
				next_rdata[4:0] = wait_states_out;
				next_rdata[8]   = erase_retry_mode_out;
				next_rdata[9]   = (key_state == flash_ctrl_pkg::KEY_OPEN);
			end
		end
	end

	// read data stands for one cycle only, zero otherwise
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			reg_rdata_out <= `REG_RESET;
		else
			reg_rdata_out <= next_rdata;
	end

	assign path.verify_sel     = verify_read_one_sel;
	assign path.target_addr    = flash_target_address;
	assign path.lp_ws_panel0   = lp_ws_panel0;
	assign path.lp_ws_panel1   = lp_ws_panel1;
	assign path.normal_ws      = normal_waitstates_in;
	assign path.compare_active = compare_read_one_en && verify_read_one_sel;
	assign path.flash_word     = flash_word_in;
	assign path.word_sel       = flash_word_sel_in;

	waitstate_sel u_ws (
		.path (path.ws_unit)
	);

	compare_read_eval u_cmp (
		.path (path.cmp_unit)
	);

	// registered so timing toward the array does not see the mux chain
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			flash_rd_data_out <= `REG_RESET;
		else if (flash_rd_in)
			flash_rd_data_out <= path.read_word;
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			wait_states_out <= `WS_RESET;
		else
			wait_states_out <= path.ws_sel;
	end

	// strength is held at the first code outside retry mode; software steps it up
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			erase_retry_mode_out     <= 1'b0;
			erase_retry_strength_out <= `RETRY_FIRST;
		end
		else
		begin
			erase_retry_mode_out     <= (erase_mode == flash_ctrl_pkg::ERASE_RETRY);
			erase_retry_strength_out <= verify_read_one_sel ? erase_retry_strength
			                                                : `RETRY_FIRST;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			program_panel_swap_out   <= 1'b0;
			boot_panel_swap_out      <= 1'b0;
			flash_target_address_out <= `REG_RESET;
		end
		else
		begin
			program_panel_swap_out   <= program_panel_swap;
			boot_panel_swap_out      <= boot_panel_swap;
			flash_target_address_out <= flash_target_address;
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_all_ones_read;
		flash_rd_in && compare_read_one_en && verify_read_one_sel && (&flash_word_in);
	endsequence

	sequence s_key_opened;
		reg_wr_in && hit(reg_addr_in, `KEY_OFFSET) && reg_wdata_in == `KEY_FIRST
		##1 reg_wr_in && hit(reg_addr_in, `KEY_OFFSET) && reg_wdata_in == `KEY_SECOND;
	endsequence

	a_cmp_gated_off: assert property (
		flash_rd_in && !verify_read_one_sel |=> flash_rd_data_out == $past(flash_word_in[31:0])
		|| $past(flash_word_sel_in) != 2'b00)
		else $error("compare read acted without verify bit");

	a_cmp_low_word: assert property (
		s_all_ones_read ##0 flash_word_sel_in == 2'b00 |=> flash_rd_data_out == `CMP_LOW_WORD)
		else $error("all-ones lowest word not 1");

	a_cmp_other_word: assert property (
		s_all_ones_read ##0 flash_word_sel_in != 2'b00 |=> flash_rd_data_out == `CMP_OTHER_WORD)
		else $error("all-ones upper word not 0x10000");

	a_cmp_fail_word: assert property (
		flash_rd_in && compare_read_one_en && verify_read_one_sel && !(&flash_word_in)
		|=> flash_rd_data_out == `CMP_FAIL_WORD)
		else $error("compare read with a zero bit not zero");

	a_erase_mode_sel: assert property (
		##1 erase_retry_mode_out == $past(verify_read_one_sel))
		else $error("erase mode does not follow verify bit");

	a_ws_panel_src: assert property (
		verify_read_one_sel |=>
		wait_states_out == ($past(flash_target_address[`PANEL_ADDR_BIT]) ? $past(lp_ws_panel1)
		                                                                 : $past(lp_ws_panel0)))
		else $error("wait states not from addressed panel field");

	a_retry_pass: assert property (
		verify_read_one_sel |=> erase_retry_strength_out == $past(erase_retry_strength))
		else $error("retry strength code not applied");

	a_retry_ignored: assert property (
		!verify_read_one_sel |=> erase_retry_strength_out == `RETRY_FIRST)
		else $error("retry strength applied without verify");

	a_swap_open_write: assert property (
		swap_wr && panel_swap_lock == `LOCK_OPEN |=>
		program_panel_swap == $past(reg_wdata_in[`PSWAP_BIT])
		&& boot_panel_swap == $past(reg_wdata_in[`BSWAP_BIT]))
		else $error("swap bit write lost while unlocked");

	a_swap_blocked: assert property (
		swap_wr && panel_swap_lock != `LOCK_OPEN |=> $stable(program_panel_swap)
		&& $stable(boot_panel_swap))
		else $error("swap bits changed while locked");

	a_lock_final_hold: assert property (
		panel_swap_lock == `LOCK_FINAL |=> panel_swap_lock == `LOCK_FINAL [*3])
		else $error("final lock code was released");

	a_ctrl_guarded: assert property (
		ctrl_wr && !protected_ok |=> $stable(verify_read_one_sel) && $stable(compare_read_one_en)
		&& $stable(erase_retry_strength))
		else $error("protected control changed without unlock");

	a_key_then_write: assert property (
		s_key_opened ##1 ctrl_wr && !flash_write_enable |=>
		verify_read_one_sel == $past(reg_wdata_in[`VRFY_BIT]))
		else $error("unlocked control write not taken");

	a_unused_zero: assert property (
		reg_rd_in && hit(reg_addr_in, `FPC2_OFFSET) |=>
		reg_rdata_out[11:10] == 2'b00 && reg_rdata_out[5:0] == 6'h00)
		else $error("unused control bits read nonzero");

endmodule // flash_verify_retry_panel_swap_lock_ctrl

// *** rtl/waitstate_sel.sv ***
/*
	wait-state source selection for flash reads
	assumes the top registers the result before it leaves the block
*/
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"

module waitstate_sel (
	flash_path_if.ws_unit  path
);
	// panel chosen by one address bit; the top half of the map is panel one
	always_comb
	begin
		if (path.verify_sel)
		begin
			if (path.target_addr[`PANEL_ADDR_BIT])
				path.ws_sel = path.lp_ws_panel1;
			else
				path.ws_sel = path.lp_ws_panel0;
		end
		else
			path.ws_sel = path.normal_ws;
	end
endmodule // waitstate_sel

// *** shared/flash_ctrl_map.svh ***
/*
	offsets, field positions, reset values and codes of the flash program control block
	assumes a byte-addressed 8-bit register port with one 32-bit word per register
*/
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

`define FPC2_OFFSET        8'h00
`define SWAP_OFFSET        8'h04
`define CTRL1_OFFSET       8'h08
`define KEY_OFFSET         8'h0c
`define LPWS_OFFSET        8'h10
`define ADDR_OFFSET        8'h14
`define STATUS_OFFSET      8'h18

`define CMP_RD_BIT         13
`define VRFY_BIT           12
`define RETRY_HI           9
`define RETRY_LO           8
`define LOCK_HI            7
`define LOCK_LO            6
`define WEN_BIT            0
`define PSWAP_BIT          0
`define BSWAP_BIT          1
`define LPWS0_LO           0
`define LPWS1_LO           8
`define WS_W               5
`define PANEL_ADDR_BIT     20

`define LOCK_OPEN          2'b00
`define LOCK_FINAL         2'b11
`define RETRY_FIRST        2'b00

`define CMP_LOW_WORD       32'h0000_0001
`define CMP_OTHER_WORD     32'h0001_0000
`define CMP_FAIL_WORD      32'h0000_0000

`define REG_RESET          32'h0000_0000
`define WS_RESET           5'h00

// unlock key values are arbitrary
`define KEY_FIRST          32'h1234_5678
`define KEY_SECOND         32'h8765_4321

`endif

// *** shared/flash_ctrl_pkg.sv ***
/*
	types shared by the flash program control block
	assumes flash_ctrl_map.svh supplies the numeric constants
*/
package flash_ctrl_pkg;

	typedef enum logic {ERASE_SINGLE, ERASE_RETRY} erase_mode_t;

	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;

	typedef logic [4:0] waitstate_t;

endpackage

// *** shared/flash_path_if.sv ***
/*
	interface between the control top and its wait-state and compare-read units
	assumes all signals live in the system clock domain
*/
`timescale 1ns/10ps

interface flash_path_if;
	logic                        verify_sel;
	logic [31:0]                 target_addr;
	flash_ctrl_pkg::waitstate_t  lp_ws_panel0;
	flash_ctrl_pkg::waitstate_t  lp_ws_panel1;
	flash_ctrl_pkg::waitstate_t  normal_ws;
	flash_ctrl_pkg::waitstate_t  ws_sel;
	logic                        compare_active;
	logic [127:0]                flash_word;
	logic [1:0]                  word_sel;
	logic [31:0]                 read_word;

	modport ctrl (
		output verify_sel, target_addr, lp_ws_panel0, lp_ws_panel1, normal_ws,
		output compare_active, flash_word, word_sel,
		input  ws_sel, read_word
	);
	modport ws_unit (
		input  verify_sel, target_addr, lp_ws_panel0, lp_ws_panel1, normal_ws,
		output ws_sel
	);
	modport cmp_unit (
		input  compare_active, flash_word, word_sel,
		output read_word
	);
endinterface

// *** tb/tb_flash_verify_retry_panel_swap_lock_ctrl.sv ***
/*
	self-checking bench of the flash program control block, with a bench model of its registers
	assumes the offsets, key values and field positions of flash_ctrl_map.svh
*/
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"

module tb_flash_verify_retry_panel_swap_lock_ctrl;
	logic          sys_clk_in;
	logic          rst_in;
	logic [7:0]    reg_addr_in;
	logic [31:0]   reg_wdata_in;
	logic          reg_wr_in;
	logic          reg_rd_in;
	logic [31:0]   reg_rdata_out;
	logic          flash_rd_in;
	logic [127:0]  flash_word_in;
	logic [1:0]    flash_word_sel_in;
	logic [31:0]   flash_rd_data_out;
	logic [4:0]    normal_waitstates_in;
	logic [4:0]    wait_states_out;
	logic          erase_retry_mode_out;
	logic [1:0]    erase_retry_strength_out;
	logic          program_panel_swap_out;
	logic          boot_panel_swap_out;
	logic [31:0]   flash_target_address_out;
	int            failures;
	int            samples_checked;
	logic [31:0]   seed;
	logic [31:0]   t;
	logic [31:0]   m_ctrl;
	logic [31:0]   m_swap;
	logic [31:0]   m_wen;
	logic [31:0]   m_lpws;
	logic [31:0]   m_addr;
	int            m_key;

	flash_verify_retry_panel_swap_lock_ctrl u_flash_verify_retry_panel_swap_lock_ctrl (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .flash_rd_in(flash_rd_in), .flash_word_in(flash_word_in),
		.flash_word_sel_in(flash_word_sel_in), .flash_rd_data_out(flash_rd_data_out),
		.normal_waitstates_in(normal_waitstates_in), .wait_states_out(wait_states_out),
		.erase_retry_mode_out(erase_retry_mode_out),
		.erase_retry_strength_out(erase_retry_strength_out),
		.program_panel_swap_out(program_panel_swap_out),
		.boot_panel_swap_out(boot_panel_swap_out),
		.flash_target_address_out(flash_target_address_out)
	);

	initial
	begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		rnd = seed;
	endfunction

	// verify clear hands timing back to the normal source
	function automatic logic [4:0] m_ws();
		if (!m_ctrl[`VRFY_BIT])
			m_ws = normal_waitstates_in;
		else if (m_addr[`PANEL_ADDR_BIT])
			m_ws = m_lpws[12:8];
		else
			m_ws = m_lpws[4:0];
	endfunction

	function automatic logic [31:0] m_read(input logic [7:0] a);
		case (a)
			`FPC2_OFFSET: m_read = m_ctrl;
			`SWAP_OFFSET: m_read = m_swap;
			`CTRL1_OFFSET: m_read = m_wen;
			`LPWS_OFFSET: m_read = m_lpws;
			`ADDR_OFFSET: m_read = m_addr;
			`STATUS_OFFSET: m_read = {22'h0, m_key == 2, m_ctrl[`VRFY_BIT], 3'h0, m_ws()};
			default: m_read = 32'h0;
		endcase
	endfunction

	task automatic m_clear();
		m_ctrl = 32'h0;
		m_swap = 32'h0;
		m_wen = 32'h0;
		m_lpws = 32'h0;
		m_addr = 32'h0;
		m_key = 0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// the strobe is left high so that writes may follow with no gap
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		k = m_key;
		m_key = 0;
		case (a)
			`FPC2_OFFSET:
			begin
				if (k == 2 && !m_wen[0])
					m_ctrl = (m_ctrl & 32'h0000_00c0) | (d & 32'h0000_3300);
				if (m_ctrl[7:6] != `LOCK_FINAL)
					m_ctrl[7:6] = d[7:6];
			end
			`SWAP_OFFSET: if (m_ctrl[7:6] == `LOCK_OPEN) m_swap = d & 32'h3;
			`CTRL1_OFFSET: m_wen = d & 32'h1;
			`KEY_OFFSET: m_key = (k == 1 && d == `KEY_SECOND) ? 2 : (d == `KEY_FIRST) ? 1 : 0;
			`LPWS_OFFSET: m_lpws = d & 32'h1f1f;
			`ADDR_OFFSET: m_addr = d;
			default: ;
		endcase
		reg_wr_in <= 1'b1;
		reg_rd_in <= 1'b0;
		flash_rd_in <= 1'b0;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
	endtask

	task automatic rd(input logic [7:0] a);
		reg_rd_in <= 1'b1;
		reg_wr_in <= 1'b0;
		flash_rd_in <= 1'b0;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk("reg_rdata", m_read(a), reg_rdata_out);
	endtask

	task automatic idle(input int n);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		flash_rd_in <= 1'b0;
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic kwr(input logic [31:0] d);
		wr(`KEY_OFFSET, `KEY_FIRST);
		wr(`KEY_OFFSET, `KEY_SECOND);
		wr(`FPC2_OFFSET, d);
	endtask

	task automatic frd(input logic [127:0] w, input logic [1:0] s);
		logic [31:0] e;
		if (m_ctrl[`CMP_RD_BIT] && m_ctrl[`VRFY_BIT])
			e = (&w) ? ((s == 2'd0) ? `CMP_LOW_WORD : `CMP_OTHER_WORD) : `CMP_FAIL_WORD;
		else
			e = w[s*32 +: 32];
		flash_rd_in <= 1'b1;
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		flash_word_in <= w;
		flash_word_sel_in <= s;
		@(posedge sys_clk_in);
		flash_rd_in <= 1'b0;
		#1;
		chk("flash_rd_data", e, flash_rd_data_out);
	endtask

	task automatic outs();
		chk("retry_mode", {31'h0, m_ctrl[12]}, {31'h0, erase_retry_mode_out});
		chk("retry_strength", {30'h0, m_ctrl[12] ? m_ctrl[9:8] : 2'b00},
			{30'h0, erase_retry_strength_out});
		chk("wait_states", {27'h0, m_ws()}, {27'h0, wait_states_out});
		chk("swap_bits", m_swap, {30'h0, boot_panel_swap_out, program_panel_swap_out});
		chk("target_addr", m_addr, flash_target_address_out);
	endtask

	task automatic close_out();
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	initial
	begin
		#(40 * 20000);
		failures++;
		close_out();
	end

	initial
	begin
		rst_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		flash_rd_in = 1'b0;
		flash_word_in = 128'h0;
		flash_word_sel_in = 2'h0;
		normal_waitstates_in = 5'h00;
		failures = 0;
		samples_checked = 0;
		seed = 32'h62a9;
		m_clear();
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		idle(1);
		for (int a = 0; a < 32; a += 4) rd(a[7:0]);
		wr(`FPC2_OFFSET, 32'hffff_ff3f);
		rd(`FPC2_OFFSET);
		kwr(32'hffff_ff3f);
		rd(`FPC2_OFFSET);
		idle(1);
		outs();
		wr(`CTRL1_OFFSET, 32'h1);
		kwr(32'h0);
		rd(`FPC2_OFFSET);
		wr(`CTRL1_OFFSET, 32'h0);
		for (int r = 0; r < 4; r++)
		begin
			kwr(32'h1000 | (r << 8));
			idle(1);
			outs();
			kwr(r << 8);
			idle(1);
			outs();
		end
		t = rnd();
		normal_waitstates_in <= t[4:0];
		wr(`LPWS_OFFSET, rnd());
		for (int p = 0; p < 4; p++)
		begin
			wr(`ADDR_OFFSET, (rnd() & 32'hffef_ffff) | {11'h0, p[0], 20'h0});
			kwr({19'h0, p[1], 12'h0});
			idle(1);
			outs();
			rd(`STATUS_OFFSET);
		end
		for (int m = 0; m < 3; m++)
		begin
			kwr(m == 0 ? 32'h0 : m == 1 ? 32'h2000 : 32'h3000);
			for (int s = 0; s < 4; s++)
			begin
				frd({128{1'b1}}, s[1:0]);
				t = rnd();
				frd(~(128'h1 << t[6:0]), s[1:0]);
				frd({rnd(), rnd(), rnd(), rnd()}, s[1:0]);
			end
		end
		wr(`SWAP_OFFSET, 32'h3);
		idle(1);
		outs();
		wr(`FPC2_OFFSET, 32'h40);
		wr(`SWAP_OFFSET, 32'h0);
		wr(`FPC2_OFFSET, 32'h80);
		wr(`SWAP_OFFSET, 32'h0);
		rd(`SWAP_OFFSET);
		rd(`FPC2_OFFSET);
		wr(`FPC2_OFFSET, 32'h0);
		wr(`SWAP_OFFSET, 32'h1);
		rd(`SWAP_OFFSET);
		wr(`FPC2_OFFSET, 32'hc0);
		wr(`SWAP_OFFSET, 32'h2);
		wr(`FPC2_OFFSET, 32'h0);
		rd(`FPC2_OFFSET);
		rd(`SWAP_OFFSET);
		idle(1);
		outs();
		// a final lock only leaves through reset
		rst_in <= 1'b1;
		idle(2);
		rst_in <= 1'b0;
		m_clear();
		idle(1);
		rd(`FPC2_OFFSET);
		outs();
		idle(2);
		close_out();
	end
endmodule // tb_flash_verify_retry_panel_swap_lock_ctrl
